/* File: logic/reset_strap_defines.svh */
// Constants for the reset strap sampler
`ifndef RESET_STRAP_DEFINES_SVH
`define RESET_STRAP_DEFINES_SVH
`define STRAP_NUM_PINS      16
`define STRAP_PROTO_PIN     9
`define STRAP_HIGH_PIN      8
`define STRAP_SEL_WIDTH     4
`define STRAP_IDX_WIDTH     8
`define STRAP_DEF_SEL_LSB   0
`define STRAP_FUNC_WIDTH    2
`define STRAP_FUNC_NONE     2'h0
`define STRAP_FUNC_SEL      2'h1
`define STRAP_FUNC_EEDIS    2'h2
`define STRAP_FUNC_ADDR     2'h3
`endif

/* File: logic/reset_strap_pkg.sv */
// Types for the reset strap sampler
`default_nettype none
package reset_strap_pkg;
  typedef enum logic [1:0] {
    ST_RESET   = 2'h0,
    ST_CAPTURE = 2'h1,
    ST_HOLD    = 2'h2
  } strap_state_e;
  typedef enum logic {
    PROTO_SPI = 1'h0,
    PROTO_I2C = 1'h1
  } host_proto_e;
endpackage
`default_nettype wire

/* File: logic/reset_strap_sampler.sv */
// Strap sampler capturing pin levels at master reset release
//
// Summary of operation
// R01 - Capture all pins at reset release edge
// R02 - Pin 9 low SPI, high I2C
// R03 - Board holds pin 8 high during reset
// R04 - Address pin level gives bit two, else zero
// R05 - Several address pins: highest index wins
// R06 - Address strap ignored in SPI mode
// R07 - High disable pin stops EEPROM reads
// R08 - Several disable pins combine as OR
// R09 - No selector pins: use pins 3 to 0
// R10 - Undriven default selectors give configuration 15
// R11 - Selector bits ordered by pin index
// R12 - Few selectors fill low bits, zeros above
// R13 - More than four selectors widen index
// R14 - Selection ignored on unprogrammed parts
// R15 - Function map from factory block, else default
// R16 - Strap results writable after reset; code lets writes change only the protocol and address bit
// R17 - Defaults: clocks off, pins inputs
// R18 - Every pin pulled up by default
// R19 - Integrator avoids test-port and reused pins
// R20 - Checksum failure keeps register defaults
// R21 - SPI mode skips EEPROM search
// R22 - Captured values held until next reset
`include "reset_strap_defines.svh"
`default_nettype none
module reset_strap_sampler #(
  parameter int NUM_PINS  = `STRAP_NUM_PINS,
  parameter int IDX_WIDTH = `STRAP_IDX_WIDTH,
  parameter int NUM_CLK   = 12
) (
  // Clock and reset
  input  wire logic                               clock_i,
  input  wire logic                               rst_i,
  input  wire logic                               master_reset_low_i,
  // Pins and factory map
  input  wire logic [NUM_PINS-1:0]                pin_i,
  input  wire logic [NUM_PINS*`STRAP_FUNC_WIDTH-1:0] func_map_i,
  input  wire logic                               map_valid_i,
  // Configuration loader status
  input  wire logic                               otp_programmed_i,
  input  wire logic                               cfg_load_i,
  input  wire logic                               cfg_csum_ok_i,
  // Later serial port writes
  input  wire logic                               wr_proto_i,
  input  wire logic                               wr_proto_val_i,
  input  wire logic                               wr_addr_i,
  input  wire logic                               wr_addr_val_i,
  // Strap results
  output logic                                    proto_i2c_o,
  output logic                                    slave_addr_bit_two_o,
  output logic                                    eeprom_search_o,
  output logic [IDX_WIDTH-1:0]                    startup_config_set_o,
  output logic                                    cfg_sel_valid_o,
  output logic                                    cfg_apply_o,
  output logic                                    strap_valid_o,
  output logic                                    pin8_fault_o,
  // Pin defaults
  output logic [NUM_PINS-1:0]                     pin_pullup_o,
  output logic [NUM_PINS-1:0]                     pin_oe_o,
  output logic [NUM_CLK-1:0]                      clk_out_en_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Function map per pin
  logic [NUM_PINS-1:0] is_sel;
  logic [NUM_PINS-1:0] is_eedis;
  logic [NUM_PINS-1:0] is_addr;

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_map
      logic [`STRAP_FUNC_WIDTH-1:0] f;
      // Without a valid factory map no pin sees any assignment
      assign f = map_valid_i ? func_map_i[g*`STRAP_FUNC_WIDTH +: `STRAP_FUNC_WIDTH]
                             : `STRAP_FUNC_NONE; // R15
      assign is_sel[g]   = (f == `STRAP_FUNC_SEL);
      assign is_eedis[g] = (f == `STRAP_FUNC_EEDIS);
      assign is_addr[g]  = (f == `STRAP_FUNC_ADDR);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Release edge detect and sequencing
  reset_strap_pkg::strap_state_e state_q;
  logic                          mr_q;
  logic                          release_edge;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mr_q <= 1'h0;
    end else begin
      mr_q <= master_reset_low_i;
    end
  end

  assign release_edge = master_reset_low_i & ~mr_q; // R01

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= reset_strap_pkg::ST_RESET;
    end else begin
      case (state_q)
        reset_strap_pkg::ST_RESET: begin
          if (release_edge) begin
            state_q <= reset_strap_pkg::ST_CAPTURE;
          end
        end
        reset_strap_pkg::ST_CAPTURE: begin
          // A reset pulse here must not strand the machine in hold
          if (!master_reset_low_i) begin
            state_q <= reset_strap_pkg::ST_RESET;
          end else begin
            state_q <= reset_strap_pkg::ST_HOLD;
          end
        end
        reset_strap_pkg::ST_HOLD: begin
          if (!master_reset_low_i) begin
            state_q <= reset_strap_pkg::ST_RESET;
          end
        end
        default: begin
          state_q <= reset_strap_pkg::ST_RESET;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin capture, held until the next reset release
  logic [NUM_PINS-1:0] pins_q;
  logic                valid_q;
  logic                pin8_low_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pins_q <= '1;
    end else if (release_edge) begin
      pins_q <= pin_i; // R01 R22
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      valid_q <= 1'h0;
    end else if (!master_reset_low_i) begin
      valid_q <= 1'h0;
    end else if (state_q == reset_strap_pkg::ST_CAPTURE) begin
      // Rises with the loaded results, so no stale index or search leaks out
      valid_q <= 1'h1; // R14 R21
    end
  end

  // Pin 8 low while reset is held is the board's fault; flagged only
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pin8_low_q <= 1'h0;
    end else if (release_edge) begin
      pin8_low_q <= 1'h0;
    end else if (!master_reset_low_i && !pin_i[`STRAP_HIGH_PIN]) begin
      pin8_low_q <= 1'h1; // R03
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode of captured levels
  logic                 addr_bit;
  logic                 eedis;
  logic [IDX_WIDTH-1:0] sel_idx;
  logic                 any_sel;

  always_comb begin
    addr_bit = 1'h0;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (is_addr[i]) begin
        addr_bit = pins_q[i]; // R04 R05
      end
    end
  end

  assign eedis   = |(is_eedis & pins_q); // R07 R08
  assign any_sel = |is_sel;

  always_comb begin
    int unsigned k;
    k = 0;
    sel_idx = '0; // R12
    if (!any_sel) begin
      sel_idx[`STRAP_SEL_WIDTH-1:0] =
        pins_q[`STRAP_DEF_SEL_LSB +: `STRAP_SEL_WIDTH]; // R09 R10
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (is_sel[i] && k < IDX_WIDTH) begin
          sel_idx[k] = pins_q[i]; // R11 R13
          k = k + 1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result registers; protocol and address bit writable
  logic proto_q;
  logic addr_q;
  logic [IDX_WIDTH-1:0] idx_q;
  logic eedis_q;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      proto_q <= 1'h1;
    end else if (state_q == reset_strap_pkg::ST_CAPTURE) begin
      proto_q <= pins_q[`STRAP_PROTO_PIN]; // R02
    end else if (wr_proto_i) begin
      proto_q <= wr_proto_val_i; // R16
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      addr_q <= 1'h0;
    end else if (state_q == reset_strap_pkg::ST_CAPTURE) begin
      addr_q <= addr_bit;
    end else if (wr_addr_i) begin
      addr_q <= wr_addr_val_i; // R16
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      idx_q   <= '0;
      eedis_q <= 1'h0;
    end else if (state_q == reset_strap_pkg::ST_CAPTURE) begin
      idx_q   <= sel_idx;
      eedis_q <= eedis;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign proto_i2c_o          = proto_q;
  assign slave_addr_bit_two_o = (proto_q == reset_strap_pkg::PROTO_I2C) & addr_q; // R06
  assign eeprom_search_o      = valid_q & proto_q & ~eedis_q; // R07 R21
  assign startup_config_set_o = idx_q;
  assign cfg_sel_valid_o      = valid_q & otp_programmed_i; // R14
  // A bad checksum leaves the defaults in place
  assign cfg_apply_o          = cfg_sel_valid_o & cfg_load_i & cfg_csum_ok_i; // R20
  assign strap_valid_o        = valid_q;
  assign pin8_fault_o         = pin8_low_q;
  assign pin_pullup_o         = '1; // R18
  assign pin_oe_o             = '0; // R17
  assign clk_out_en_o         = '0; // R17

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  localparam int CNT_W = $clog2(NUM_PINS + 1);
  logic [CNT_W-1:0] sel_count;

  // Selector count, read only by the width check
  always_comb begin
    sel_count = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      sel_count = sel_count + CNT_W'(is_sel[i]);
    end
  end

  AST_CAPTURE_HOLD: assert property (@(posedge clock_i) disable iff (rst_i) // R22
    (state_q == reset_strap_pkg::ST_HOLD && master_reset_low_i) |=> $stable(pins_q))
    else $error("Captured pins changed while held");
  AST_CAPTURE_EDGE: assert property (@(posedge clock_i) disable iff (rst_i) // R01
    release_edge |=> (pins_q == $past(pin_i)))
    else $error("Pins not captured at release");
  AST_PROTO: assert property (@(posedge clock_i) disable iff (rst_i) // R02
    (state_q == reset_strap_pkg::ST_CAPTURE) |=> (proto_q == $past(pins_q[`STRAP_PROTO_PIN])))
    else $error("Protocol not taken from pin 9");
  AST_ADDR_SPI: assert property (@(posedge clock_i) disable iff (rst_i) // R06
    !proto_q |-> !slave_addr_bit_two_o)
    else $error("Address bit active in SPI mode");
  AST_ADDR_NONE: assert property (@(posedge clock_i) disable iff (rst_i) // R04
    (state_q == reset_strap_pkg::ST_CAPTURE && !(|is_addr)) |=> !addr_q)
    else $error("Address bit set with no address pin");
  AST_EE_SPI: assert property (@(posedge clock_i) disable iff (rst_i) // R21
    !proto_q |-> !eeprom_search_o)
    else $error("EEPROM search in SPI mode");
  AST_EE_OR: assert property (@(posedge clock_i) disable iff (rst_i) // R08
    (state_q == reset_strap_pkg::ST_CAPTURE && |(is_eedis & pins_q)) |=> !eeprom_search_o)
    else $error("EEPROM disable pin ignored");
  AST_DEF_SEL: assert property (@(posedge clock_i) disable iff (rst_i) // R09
    (state_q == reset_strap_pkg::ST_CAPTURE && !any_sel)
      |=> (idx_q == IDX_WIDTH'($past(pins_q[3:0]))))
    else $error("Default selector index wrong");
  AST_CSUM: assert property (@(posedge clock_i) disable iff (rst_i) // R20
    !cfg_csum_ok_i |-> !cfg_apply_o)
    else $error("Configuration applied despite bad checksum");
  AST_UNPROG: assert property (@(posedge clock_i) disable iff (rst_i) // R14
    !otp_programmed_i |-> !cfg_sel_valid_o)
    else $error("Selection valid on unprogrammed part");
  // Nothing qualifies the results before they are loaded
  AST_NO_EARLY: assert property (@(posedge clock_i) disable iff (rst_i) // R21
    (state_q == reset_strap_pkg::ST_CAPTURE) |-> (!eeprom_search_o && !cfg_sel_valid_o))
    else $error("Stale results qualified during capture");
  AST_EE_STRAP_SPI: assert property (@(posedge clock_i) disable iff (rst_i) // R21
    (state_q == reset_strap_pkg::ST_CAPTURE && !pins_q[`STRAP_PROTO_PIN]) |=> !eeprom_search_o)
    else $error("EEPROM search after SPI strap");
  AST_EE_NONE: assert property (@(posedge clock_i) disable iff (rst_i) // R07
    (state_q == reset_strap_pkg::ST_CAPTURE && !(|is_eedis) && master_reset_low_i
      && pins_q[`STRAP_PROTO_PIN]) |=> eeprom_search_o)
    else $error("EEPROM search missing with no disable pin");
  AST_PIN8_FLAG: assert property (@(posedge clock_i) disable iff (rst_i) // R03
    (!master_reset_low_i && !pin_i[`STRAP_HIGH_PIN]) |=> pin8_fault_o)
    else $error("Pin 8 low in reset not flagged");
  AST_PIN8_CLEAR: assert property (@(posedge clock_i) disable iff (rst_i) // R03
    release_edge |=> !pin8_fault_o)
    else $error("Pin 8 flag not cleared at release");
  AST_ONE_CAPTURE: assert property (@(posedge clock_i) disable iff (rst_i) // R01
    release_edge |=> (state_q == reset_strap_pkg::ST_CAPTURE))
    else $error("Release edge did not start a capture");
  AST_HOLD_IDX: assert property (@(posedge clock_i) disable iff (rst_i) // R22
    (state_q == reset_strap_pkg::ST_HOLD && master_reset_low_i) |=> $stable(idx_q))
    else $error("Configuration index changed while held");
  AST_VALID_DROP: assert property (@(posedge clock_i) disable iff (rst_i) // R01
    !master_reset_low_i |=> !strap_valid_o)
    else $error("Strap results valid during master reset");
  AST_WR_PROTO: assert property (@(posedge clock_i) disable iff (rst_i) // R16
    (wr_proto_i && state_q != reset_strap_pkg::ST_CAPTURE)
      |=> (proto_q == $past(wr_proto_val_i)))
    else $error("Protocol write lost");
  AST_WR_ADDR: assert property (@(posedge clock_i) disable iff (rst_i) // R16
    (wr_addr_i && state_q != reset_strap_pkg::ST_CAPTURE)
      |=> (addr_q == $past(wr_addr_val_i)))
    else $error("Address bit write lost");
  AST_ADDR_TOP: assert property (@(posedge clock_i) disable iff (rst_i) // R05
    (state_q == reset_strap_pkg::ST_CAPTURE && is_addr[NUM_PINS-1])
      |=> (addr_q == $past(pins_q[NUM_PINS-1])))
    else $error("Highest address pin not used");
  AST_SEL_LOW: assert property (@(posedge clock_i) disable iff (rst_i) // R12
    (state_q == reset_strap_pkg::ST_CAPTURE && any_sel
      && sel_count <= CNT_W'(`STRAP_SEL_WIDTH)) |=> ((idx_q >> `STRAP_SEL_WIDTH) == '0))
    else $error("Unused upper selector bits not zero");

  COV_I2C: cover property (@(posedge clock_i) disable iff (rst_i)
    (state_q == reset_strap_pkg::ST_CAPTURE) ##1 proto_q);
  COV_SPI: cover property (@(posedge clock_i) disable iff (rst_i)
    (state_q == reset_strap_pkg::ST_CAPTURE) ##1 !proto_q);
  COV_CFG15: cover property (@(posedge clock_i) disable iff (rst_i)
    valid_q && idx_q == IDX_WIDTH'(15));
  COV_APPLY: cover property (@(posedge clock_i) disable iff (rst_i) cfg_apply_o);
  COV_PIN8: cover property (@(posedge clock_i) disable iff (rst_i) pin8_low_q);

endmodule
`default_nettype wire

/* File: test/strap_board_model.sv */
// Board model: pin pull-ups, optional strap drivers, pin 8 held high in reset
`default_nettype none
module strap_board_model (
  // Reset seen by the board
  input  wire logic        master_reset_low_i,
  // Board keeps pin 8 high in reset when set; cleared only to model a faulty board
  input  wire logic        pin8_hold_i,
  // Strap drivers
  input  wire logic [15:0] drive_en_i,
  input  wire logic [15:0] drive_val_i,
  // Resolved pin levels
  output logic      [15:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // An undriven pin settles at the pull-up level, never at a stale value
  always_comb begin
    pin_o = (drive_en_i & drive_val_i) | ~drive_en_i;
    if (!master_reset_low_i && pin8_hold_i) begin
      pin_o[8] = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: test/reset_strap_sampler_test.sv */
// Self-checking bench for the reset strap sampler
`default_nettype none
`define CHECK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module reset_strap_sampler_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = 1'b0;
  logic        rst = 1'b1;
  logic        mrl = 1'b0;
  logic [15:0] drv_en = 16'h0000;
  logic [15:0] drv_val = 16'h0000;
  logic [15:0] pins;
  logic [31:0] fmap_q = 32'h0000_0000;
  logic        mv = 1'b0;
  logic [2:0]  ld = 3'h7;
  logic        wp = 1'b0;
  logic        wpv = 1'b0;
  logic        wa = 1'b0;
  logic        wav = 1'b0;
  logic        hold8 = 1'b1;
  logic        proto, addr, search, selv, apply, valid, fault;
  logic [7:0]  idx;
  logic [15:0] pull, oe;
  logic [11:0] clk_en;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  always #4 clock_i = ~clock_i;
  strap_board_model board (.master_reset_low_i(mrl), .pin8_hold_i(hold8), .drive_en_i(drv_en),
    .drive_val_i(drv_val), .pin_o(pins));
  reset_strap_sampler dut (.clock_i(clock_i), .rst_i(rst), .master_reset_low_i(mrl),
    .pin_i(pins), .func_map_i(fmap_q), .map_valid_i(mv), .otp_programmed_i(ld[2]),
    .cfg_load_i(ld[1]), .cfg_csum_ok_i(ld[0]), .wr_proto_i(wp), .wr_proto_val_i(wpv),
    .wr_addr_i(wa), .wr_addr_val_i(wav), .proto_i2c_o(proto),
    .slave_addr_bit_two_o(addr), .eeprom_search_o(search),
    .startup_config_set_o(idx), .cfg_sel_valid_o(selv), .cfg_apply_o(apply),
    .strap_valid_o(valid), .pin8_fault_o(fault), .pin_pullup_o(pull), .pin_oe_o(oe),
    .clk_out_en_o(clk_en));
  ////////////////////////////////////////////////////////////////////////////
  // Two bits a pin: 1 selector, 2 EEPROM disable, 3 address bit
  function automatic logic [31:0] fmap(input logic [15:0] sel, ee, ad);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int g = 0; g < 16; g++) begin
      m[2*g+:2] = ad[g] ? 2'h3 : ee[g] ? 2'h2 : sel[g] ? 2'h1 : 2'h0;
    end
    return m;
  endfunction
  // Pins are set while the master reset is low, so they are settled at release
  task automatic strap(input logic v, input logic [31:0] m, input logic [15:0] en, val);
    @(negedge clock_i);
    mrl = 1'b0;
    mv = v;
    fmap_q = m;
    drv_en = en;
    drv_val = val;
    repeat (3) @(negedge clock_i);
    `CHECK(valid, 1'b0)
    `CHECK(fault, !hold8 && en[8] && !val[8])
    mrl = 1'b1;
    @(negedge clock_i);
    `CHECK(search, 1'b0)
    `CHECK(selv, 1'b0)
    repeat (2) @(negedge clock_i);
    `CHECK(valid, 1'b1)
    `CHECK(fault, 1'b0)
  endtask
  task automatic expect_res(input logic p, a, s, input logic [7:0] i);
    `CHECK(proto, p)
    `CHECK(addr, a)
    `CHECK(search, s)
    `CHECK(idx, i)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Unmapped part: a stray map must be ignored, pull-ups give index 15
  task automatic t_default();
    strap(1'b0, fmap(16'h0000, 16'hFFFF, 16'h0000), 16'h0000, 16'h0000);
    expect_res(reset_strap_pkg::PROTO_I2C, 1'b0, 1'b1, 8'h0F);
    `CHECK(pull, 16'hFFFF)
    `CHECK({oe, clk_en}, 28'h0000000)
  endtask
  // SPI: address strap and EEPROM search both suppressed
  task automatic t_spi();
    strap(1'b1, fmap(16'h0000, 16'h0000, 16'h1000), 16'h120F, 16'h1005);
    expect_res(reset_strap_pkg::PROTO_SPI, 1'b0, 1'b0, 8'h05);
  endtask
  // Scattered selectors, two address pins, two disable pins, then pin noise
  task automatic t_mapped();
    strap(1'b1, fmap(16'h0164, 16'h3000, 16'h0480), 16'h34E4, 16'h2444);
    expect_res(reset_strap_pkg::PROTO_I2C, 1'b1, 1'b0, 8'h0D);
    drv_val = ~drv_val;
    repeat (4) @(negedge clock_i);
    expect_res(reset_strap_pkg::PROTO_I2C, 1'b1, 1'b0, 8'h0D);
  endtask
  // Two selectors fill the low bits; six selectors widen the index
  task automatic t_width();
    strap(1'b1, fmap(16'h4400, 16'h0000, 16'h0000), 16'h4400, 16'h0400);
    expect_res(reset_strap_pkg::PROTO_I2C, 1'b0, 1'b1, 8'h01);
    strap(1'b1, fmap(16'h003F, 16'h0000, 16'h0000), 16'h003F, 16'h002D);
    expect_res(reset_strap_pkg::PROTO_I2C, 1'b0, 1'b1, 8'h2D);
  endtask
  // Every combination of programmed part, load and checksum
  task automatic t_cfg();
    for (int i = 0; i < 8; i++) begin
      @(negedge clock_i);
      ld = i[2:0];
      #1;
      `CHECK(selv, ld[2])
      `CHECK(apply, ld == 3'h7)
    end
  endtask
  // A board that lets pin 8 sag in reset is flagged until release
  task automatic t_pin8();
    hold8 = 1'b0;
    strap(1'b0, 32'h0000_0000, 16'h0100, 16'h0000);
    hold8 = 1'b1;
    expect_res(reset_strap_pkg::PROTO_I2C, 1'b0, 1'b1, 8'h0F);
  endtask
  // Serial port writes replace strapped protocol and address bit
  task automatic t_write();
    @(negedge clock_i);
    wp = 1'b1;
    wpv = 1'b0;
    @(negedge clock_i);
    wp = 1'b0;
    @(negedge clock_i);
    `CHECK(proto, reset_strap_pkg::PROTO_SPI)
    wp = 1'b1;
    wpv = 1'b1;
    wa = 1'b1;
    wav = 1'b1;
    @(negedge clock_i);
    wp = 1'b0;
    wa = 1'b0;
    @(negedge clock_i);
    `CHECK({proto, addr}, 2'h3)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("Errors %0d of %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Whole run needs under a hundred cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (3) @(negedge clock_i);
    rst = 1'b0;
    t_default();
    t_cfg();
    t_spi();
    t_mapped();
    t_width();
    t_pin8();
    t_write();
    report_and_stop();
  end
endmodule
`default_nettype wire
